// ---- pam_monitor.sv ----
// process alarm monitor for flow, pressure and temperature
// Function
// - flow condition true when deviation magnitude reaches the limit.
// - low flow alarm needs deviation at low limit, flow below set point.
// - high flow alarm needs deviation at high limit, flow above set point.
// - flow limits in tenths of percent, clamped at 110.0 percent.
// - flow alarm enable, off after reset, no flow alarm while off.
// - flow alarm activates after condition persists for action delay.
// - flow alarms inactive until power-on delay has elapsed.
// - flow latch holds output once triggered, else it follows condition.
// - valve close on selected high or low flow alarm.
// - display alert toggles once per second while any alarm active.
// - low pressure condition when pressure below low limit.
// - high pressure condition when pressure above high limit.
// - pressure limits in tenths; low 0.0..99.9, high 0.1..100.
// - pressure alarm activates after its action delay.
// - pressure alarms inactive until power-on delay elapsed.
// - pressure enable and latch, both off after reset.
// - temperature enable, off after reset, no alarm while off.
// - low temperature condition when reading below low limit.
// - low temperature limit in tenths, -20.0 to 69.9 degrees.
// - high temperature condition when reading above limit, max 70.0.
module pam_monitor #(
    parameter int TICK_CYCLES_P = pam_pkg::TICK_CYCLES
) (
    input  wire logic                      clk_i,
    input  wire logic                      sys_rst_i,
    input  wire logic [pam_pkg::VAL_W-1:0] flow_i,
    input  wire logic [pam_pkg::VAL_W-1:0] set_point_i,
    input  wire logic [pam_pkg::VAL_W-1:0] pressure_i,
    input  wire logic signed [pam_pkg::VAL_W-1:0] temperature_i,
    input  wire logic                      flow_en_i,
    input  wire logic [pam_pkg::VAL_W-1:0] flow_lo_lim_i,
    input  wire logic [pam_pkg::VAL_W-1:0] flow_hi_lim_i,
    input  wire logic [pam_pkg::DELAY_W-1:0] flow_act_dly_i,
    input  wire logic [pam_pkg::DELAY_W-1:0] flow_pon_dly_i,
    input  wire logic                      flow_latch_i,
    input  wire pam_pkg::pam_valve_type    valve_sel_i,
    input  wire logic                      pres_en_i,
    input  wire logic [pam_pkg::VAL_W-1:0] pres_lo_lim_i,
    input  wire logic [pam_pkg::VAL_W-1:0] pres_hi_lim_i,
    input  wire logic [pam_pkg::DELAY_W-1:0] pres_act_dly_i,
    input  wire logic [pam_pkg::DELAY_W-1:0] pres_pon_dly_i,
    input  wire logic                      pres_latch_i,
    input  wire logic                      temp_en_i,
    input  wire logic signed [pam_pkg::VAL_W-1:0] temp_lo_lim_i,
    input  wire logic signed [pam_pkg::VAL_W-1:0] temp_hi_lim_i,
    input  wire logic [pam_pkg::DELAY_W-1:0] temp_act_dly_i,
    input  wire logic [pam_pkg::DELAY_W-1:0] temp_pon_dly_i,
    input  wire logic                      temp_latch_i,
    output logic [5:0]                     alarm_o,
    output logic                           relay_output_o,
    output logic                           alert_show_o,
    output logic                           valve_close_o,
    output logic                           sec_tick_o
);
    import pam_pkg::*;

    // ------------------------------------------------------------
    // limit clamping and flow deviation
    // ------------------------------------------------------------
    function automatic logic [VAL_W-1:0] clamp_u(
        input logic [VAL_W-1:0] v,
        input logic [VAL_W-1:0] lo,
        input logic [VAL_W-1:0] hi
    );
        clamp_u = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic logic signed [VAL_W-1:0] clamp_s(
        input logic signed [VAL_W-1:0] v,
        input logic signed [VAL_W-1:0] lo,
        input logic signed [VAL_W-1:0] hi
    );
        clamp_s = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic logic sat_dly_eq(
        input logic [DELAY_W-1:0] cnt,
        input logic [DELAY_W-1:0] dly
    );
        logic [DELAY_W-1:0] lim;
        lim = (dly > DELAY_W'(DELAY_MAX_S)) ? DELAY_W'(DELAY_MAX_S) : dly;
        sat_dly_eq = (cnt >= lim);
    endfunction

    logic [VAL_W-1:0]        flo_lim;
    logic [VAL_W-1:0]        fhi_lim;
    logic [VAL_W-1:0]        plo_lim;
    logic [VAL_W-1:0]        phi_lim;
    logic signed [VAL_W-1:0] tlo_lim;
    logic signed [VAL_W-1:0] thi_lim;
    logic [VAL_W-1:0]        flow_dev;
    logic [5:0]              cond;
    logic [5:0]              en;
    logic [5:0]              latch;
    logic [DELAY_W-1:0]      act_dly [6];
    logic [2:0]              pon_done;

    assign flo_lim = clamp_u(flow_lo_lim_i, 16'h0000,
                             FLOW_LIM_MAX);
    assign fhi_lim = clamp_u(flow_hi_lim_i, 16'h0000,
                             FLOW_LIM_MAX);
    assign plo_lim = clamp_u(pres_lo_lim_i, 16'h0000,
                             PLO_LIM_MAX);
    assign phi_lim = clamp_u(pres_hi_lim_i, PHI_LIM_MIN,
                             PHI_LIM_MAX);
    assign tlo_lim = clamp_s(temp_lo_lim_i, TLO_LIM_MIN,
                             TLO_LIM_MAX);
    assign thi_lim = clamp_s(temp_hi_lim_i, TLO_LIM_MIN + 16'sh0001,
                             THI_LIM_MAX);
    // magnitude of flow minus set point
    assign flow_dev = (flow_i >= set_point_i)
                    ? (flow_i - set_point_i)
                    : (set_point_i - flow_i);

    // ------------------------------------------------------------
    // alarm conditions
    // ------------------------------------------------------------
    // bit order: 0 flow lo, 1 flow hi, 2 pres lo, 3 pres hi, 4 temp lo, 5 hi
    always_comb begin
        cond[0] = (flow_dev >= flo_lim)
                  && (flow_i < set_point_i);
        cond[1] = (flow_dev >= fhi_lim)
                  && (flow_i > set_point_i);
        cond[2] = pressure_i < plo_lim;
        cond[3] = pressure_i > phi_lim;
        cond[4] = temperature_i < tlo_lim;
        cond[5] = temperature_i > thi_lim;
    end

    // ------------------------------------------------------------
    // per-channel settings
    // ------------------------------------------------------------
    assign en    = {{2{temp_en_i}}, {2{pres_en_i}},
                    {2{flow_en_i}}};
    assign latch = {{2{temp_latch_i}}, {2{pres_latch_i}},
                    {2{flow_latch_i}}};
    assign act_dly[0] = flow_act_dly_i;
    assign act_dly[1] = flow_act_dly_i;
    assign act_dly[2] = pres_act_dly_i;
    assign act_dly[3] = pres_act_dly_i;
    assign act_dly[4] = temp_act_dly_i;
    assign act_dly[5] = temp_act_dly_i;

    // ------------------------------------------------------------
    // one-second tick
    // ------------------------------------------------------------
    logic [31:0] tick_cnt;
    logic [31:0] next_tick_cnt;
    logic        tick;
    logic        next_tick;

    always_comb begin
        next_tick     = 1'b0;
        next_tick_cnt = tick_cnt + 32'h1;
        if (tick_cnt >= 32'(TICK_CYCLES_P - 1)) begin
            next_tick_cnt = 32'h0;
            next_tick     = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tick_cnt <= 32'h0;
            tick     <= 1'b0;
        end else begin
            tick_cnt <= next_tick_cnt;
            tick     <= next_tick;
        end
    end

    // ------------------------------------------------------------
    // power-on delay, counted from reset release
    // ------------------------------------------------------------
    logic [DELAY_W-1:0] up_secs;
    logic [DELAY_W-1:0] next_up_secs;

    always_comb begin
        next_up_secs = up_secs;
        if (tick && up_secs != DELAY_W'(DELAY_MAX_S)) begin
            next_up_secs = up_secs + 12'h001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            up_secs <= DELAY_RST;
        end else begin
            up_secs <= next_up_secs;
        end
    end

    assign pon_done[0] = sat_dly_eq(up_secs, flow_pon_dly_i);
    assign pon_done[1] = sat_dly_eq(up_secs, pres_pon_dly_i);
    assign pon_done[2] = sat_dly_eq(up_secs, temp_pon_dly_i);

    // ------------------------------------------------------------
    // per-alarm qualification state machines
    // ------------------------------------------------------------
    pam_state_type      st      [6];
    pam_state_type      next_st [6];
    logic [DELAY_W-1:0] secs      [6];
    logic [DELAY_W-1:0] next_secs [6];
    logic [5:0]         live;

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            next_st[i]   = st[i];
            next_secs[i] = secs[i];
            live[i]      = en[i] && pon_done[i/2] && cond[i];
            unique case (st[i])
                PAM_IDLE: begin
                    next_secs[i] = DELAY_RST;
                    if (live[i]) begin
                        next_st[i] = PAM_WAIT;
                        if (sat_dly_eq(DELAY_RST, act_dly[i])) begin
                            next_st[i] = PAM_ALARM;
                        end
                    end
                end
                PAM_WAIT: begin
                    if (!live[i]) begin
                        next_st[i] = PAM_IDLE;
                    end else if (sat_dly_eq(secs[i], act_dly[i])) begin
                        next_st[i] = PAM_ALARM;
                    end else if (tick) begin
                        next_secs[i] = secs[i] + 12'h001;
                    end
                end
                PAM_ALARM: begin
                    if (!en[i]) begin
                        next_st[i] = PAM_IDLE;
                    end else if (!live[i] && !latch[i]) begin
                        next_st[i] = PAM_IDLE;
                    end
                end
                default: begin
                    next_st[i] = PAM_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        for (int i = 0; i < 6; i++) begin
            if (sys_rst_i) begin
                st[i]   <= PAM_IDLE;
                secs[i] <= DELAY_RST;
            end else begin
                st[i]   <= next_st[i];
                secs[i] <= next_secs[i];
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic [5:0] next_alarm;
    logic       next_relay;
    logic       next_valve;
    logic       next_show;

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            next_alarm[i] = (next_st[i] == PAM_ALARM);
        end
        next_relay = |next_alarm;
        unique case (valve_sel_i)
            PAM_VALVE_HIGH: next_valve = next_alarm[1];
            PAM_VALVE_LOW:  next_valve = next_alarm[0];
            default:        next_valve = 1'b0;
        endcase
        next_show = 1'b0;
        if (|next_alarm) begin
            next_show = alert_show_o;
            if (tick) begin
                next_show = !alert_show_o;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            alarm_o        <= 6'h00;
            relay_output_o <= 1'b0;
            valve_close_o  <= 1'b0;
            alert_show_o   <= 1'b0;
            sec_tick_o     <= 1'b0;
        end else begin
            alarm_o        <= next_alarm;
            relay_output_o <= next_relay;
            valve_close_o  <= next_valve;
            alert_show_o   <= next_show;
            sec_tick_o     <= tick;
        end
    end
endmodule

// ---- pam_pkg.sv ----
// package of constants and types for the process alarm monitor
package pam_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int  CLK_HZ         = 50_000_000;
    localparam int  TICK_PERIOD_S  = 1;
    localparam int  TICK_CYCLES    = CLK_HZ * TICK_PERIOD_S;
    localparam int  DELAY_MAX_S    = 3600;
    localparam int  DELAY_W        = 12;
    localparam logic [DELAY_W-1:0] DELAY_RST = 12'h000;
    // ------------------------------------------------------------
    // widths and limits (tenths of percent or tenths of degree)
    // ------------------------------------------------------------
    localparam int  VAL_W          = 16;
    localparam logic [15:0] FLOW_LIM_MAX  = 16'h044C;
    localparam logic [15:0] PLO_LIM_MAX   = 16'h03E7;
    localparam logic [15:0] PHI_LIM_MIN   = 16'h0001;
    localparam logic [15:0] PHI_LIM_MAX   = 16'h03E8;
    localparam logic signed [15:0] TLO_LIM_MIN = 16'shFF38;
    localparam logic signed [15:0] TLO_LIM_MAX = 16'sh02BB;
    localparam logic signed [15:0] THI_LIM_MAX = 16'sh02BC;
    // ------------------------------------------------------------
    // valve close selection
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PAM_VALVE_OFF  = 2'h0,
        PAM_VALVE_HIGH = 2'h1,
        PAM_VALVE_LOW  = 2'h2
    } pam_valve_type;
    // ------------------------------------------------------------
    // alarm channel states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PAM_IDLE  = 3'h1,
        PAM_WAIT  = 3'h2,
        PAM_ALARM = 3'h4
    } pam_state_type;
endpackage

// ---- pam_monitor_assertions.sv ----
// port checker for the process alarm monitor
module pam_monitor_assertions
    import pam_pkg::*;
#(
    parameter int TICK_CYCLES_P = pam_pkg::TICK_CYCLES
) (
    input  wire logic                 clk_i,
    input  wire logic                 sys_rst_i,
    input  wire logic [15:0]          flow_i,
    input  wire logic [15:0]          set_point_i,
    input  wire logic [15:0]          pressure_i,
    input  wire logic signed [15:0]   temperature_i,
    input  wire logic                 flow_en_i,
    input  wire logic [15:0]          flow_lo_lim_i,
    input  wire logic [15:0]          flow_hi_lim_i,
    input  wire logic [15:0]          pres_lo_lim_i,
    input  wire logic [15:0]          pres_hi_lim_i,
    input  wire logic signed [15:0]   temp_lo_lim_i,
    input  wire logic signed [15:0]   temp_hi_lim_i,
    input  wire pam_pkg::pam_valve_type valve_sel_i,
    input  wire logic [5:0]           alarm_o,
    input  wire logic                 relay_output_o,
    input  wire logic                 alert_show_o,
    input  wire logic                 valve_close_o,
    input  wire logic                 sec_tick_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // tick spacing counter
    // ------------------------------------------------------------
    int   gap;
    logic seen;
    int   next_gap;
    logic next_seen;
    always_comb begin
        next_gap  = sec_tick_o ? 1 : gap + 1;
        next_seen = seen | sec_tick_o;
    end
    always_ff @(posedge clk_i) begin
        gap  <= sys_rst_i ? 0 : next_gap;
        seen <= sys_rst_i ? 1'b0 : next_seen;
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_quiet;
        (alarm_o == 6'h00) [*2];
    endsequence
    sequence s_busy;
        (alarm_o != 6'h00) [*2];
    endsequence
    a_flow_off:
        assert property ((!flow_en_i) [*2] |-> alarm_o[1:0] == 2'h0)
        else $error("flow alarm while disabled");
    a_flow_low:
        assert property ($rose(alarm_o[0])
            |-> $past(flow_i) < $past(set_point_i)
            && $past(set_point_i) - $past(flow_i) >= $past(flow_lo_lim_i))
        else $error("low flow alarm without cause");
    a_flow_high:
        assert property ($rose(alarm_o[1])
            |-> $past(flow_i) > $past(set_point_i)
            && $past(flow_i) - $past(set_point_i) >= $past(flow_hi_lim_i))
        else $error("high flow alarm without cause");
    a_pres_low:
        assert property ($rose(alarm_o[2])
            |-> $past(pressure_i) < $past(pres_lo_lim_i))
        else $error("low pressure alarm without cause");
    a_pres_high:
        assert property ($rose(alarm_o[3])
            |-> $past(pressure_i) > $past(pres_hi_lim_i))
        else $error("high pressure alarm without cause");
    a_temp_low:
        assert property ($rose(alarm_o[4])
            |-> $past(temperature_i) < $past(temp_lo_lim_i))
        else $error("low temperature alarm without cause");
    a_temp_high:
        assert property ($rose(alarm_o[5])
            |-> $past(temperature_i) > $past(temp_hi_lim_i))
        else $error("high temperature alarm without cause");
    a_relay_on:
        assert property (s_busy |-> relay_output_o)
        else $error("relay off during alarm");
    a_relay_idle:
        assert property (s_quiet |-> !relay_output_o && !alert_show_o)
        else $error("relay or alert without alarm");
    a_valve_low:
        assert property ((valve_sel_i == PAM_VALVE_LOW && alarm_o[0]) [*2]
            |-> valve_close_o)
        else $error("valve open during low flow alarm");
    a_valve_off:
        assert property ((valve_sel_i == PAM_VALVE_OFF) [*2]
            |-> !valve_close_o)
        else $error("valve closed while action disabled");
    a_alert_flip:
        assert property (sec_tick_o && alarm_o != 6'h00
            |-> alert_show_o != $past(alert_show_o))
        else $error("alert did not toggle on second tick");
    a_tick_gap:
        assert property (sec_tick_o && seen |-> gap == TICK_CYCLES_P)
        else $error("second tick spacing wrong");
endmodule

bind pam_monitor pam_monitor_assertions #(
    .TICK_CYCLES_P(TICK_CYCLES_P)
) pam_monitor_assertions_inst (.*);

// ---- pam_sensor_model.sv ----
// process side model: sensor readings, valve and limit settings
module pam_sensor_model (
    input  wire logic                clk_i,
    input  wire logic                valve_close_o,
    input  wire logic [15:0]         flow_tgt,
    input  wire logic [15:0]         pres_tgt,
    input  wire logic [15:0]         temp_tgt,
    output logic [15:0]              flow_i = 16'h01F4,
    output logic [15:0]              pressure_i = 16'h01F4,
    output logic signed [15:0]       temperature_i = 16'sh0064,
    output logic [15:0]              pres_lo_lim_i,
    output logic [15:0]              pres_hi_lim_i,
    output logic signed [15:0]       temp_lo_lim_i,
    output logic signed [15:0]       temp_hi_lim_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // limits kept low below high
    assign pres_lo_lim_i = 16'h00C8;
    assign pres_hi_lim_i = 16'h0320;
    assign temp_lo_lim_i = -16'sh0032;
    assign temp_hi_lim_i = 16'sh0190;
    // closed valve stops the flow
    always @(posedge clk_i) begin
        flow_i        <= valve_close_o ? 16'h0000 : flow_tgt;
        pressure_i    <= pres_tgt;
        temperature_i <= temp_tgt;
    end
endmodule

// ---- pam_monitor_bench.sv ----
// self-checking bench of the process alarm monitor
module pam_monitor_bench;
    import pam_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK_P = 10;
    typedef struct packed {
        logic [15:0] fl;
        logic [15:0] pr;
        logic [15:0] te;
        logic [5:0]  al;
    } pam_row_type;
    pam_row_type rows [12] = '{
        '{16'h01F4, 16'h01F4, 16'h0064, 6'h00},
        '{16'h01C2, 16'h01F4, 16'h0064, 6'h01},
        '{16'h01C3, 16'h01F4, 16'h0064, 6'h00},
        '{16'h0226, 16'h01F4, 16'h0064, 6'h02},
        '{16'h01F4, 16'h00C7, 16'h0064, 6'h04},
        '{16'h01F4, 16'h00C8, 16'h0064, 6'h00},
        '{16'h01F4, 16'h0321, 16'h0064, 6'h08},
        '{16'h01F4, 16'h0320, 16'h0064, 6'h00},
        '{16'h01F4, 16'h01F4, 16'hFFCD, 6'h10},
        '{16'h01F4, 16'h01F4, 16'hFFCE, 6'h00},
        '{16'h01F4, 16'h01F4, 16'h0191, 6'h20},
        '{16'h01F4, 16'h01F4, 16'h0064, 6'h00}};
    logic clk_i = 1'b0, sys_rst_i = 1'b1, a;
    logic [15:0] set_point_i = 16'h01F4, flow_tgt = 16'h01F4;
    logic [15:0] pres_tgt = 16'h01F4, temp_tgt = 16'h0064;
    logic [15:0] flow_lo_lim_i = 16'h0032, flow_hi_lim_i = 16'h0032;
    logic flow_en_i = 1'b1, pres_en_i = 1'b1, temp_en_i = 1'b1;
    logic flow_latch_i = 1'b0, pres_latch_i = 1'b0, temp_latch_i = 1'b0;
    logic [11:0] flow_act_dly_i = 12'h000, flow_pon_dly_i = 12'h000;
    logic [11:0] pres_act_dly_i = 12'h000, pres_pon_dly_i = 12'h000;
    logic [11:0] temp_act_dly_i = 12'h000, temp_pon_dly_i = 12'h000;
    pam_valve_type valve_sel_i = PAM_VALVE_OFF;
    logic [15:0] flow_i, pressure_i, pres_lo_lim_i, pres_hi_lim_i;
    logic signed [15:0] temperature_i, temp_lo_lim_i, temp_hi_lim_i;
    logic [5:0] alarm_o;
    logic relay_output_o, alert_show_o, valve_close_o, sec_tick_o;
    int err_total = 0, n_checks = 0;
    pam_monitor #(.TICK_CYCLES_P(TICK_P)) pam_monitor_inst (.*);
    pam_sensor_model pam_sensor_model_inst (.clk_i, .valve_close_o,
        .flow_tgt, .pres_tgt, .temp_tgt, .flow_i, .pressure_i,
        .temperature_i, .pres_lo_lim_i, .pres_hi_lim_i, .temp_lo_lim_i,
        .temp_hi_lim_i);
    // ------------------------------------------------------------
    // clock, helpers, verdict
    // ------------------------------------------------------------
    initial forever #10 clk_i = ~clk_i;
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
        n_checks++;
        if (seen_v !== exp_v) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #40000;
        err_total++;
        complete_run();
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        step(6);
        chk({alarm_o, relay_output_o, alert_show_o}, 0);
        chk({valve_close_o, sec_tick_o}, 0);
        sys_rst_i = 1'b0;
        foreach (rows[i]) begin
            flow_tgt = rows[i].fl;
            pres_tgt = rows[i].pr;
            temp_tgt = rows[i].te;
            step(3);
            chk(alarm_o[1:0], rows[i].al[1:0]);
            chk(alarm_o[3:2], rows[i].al[3:2]);
            chk(alarm_o[5:4], rows[i].al[5:4]);
            chk(relay_output_o, |rows[i].al);
        end
        valve_sel_i = PAM_VALVE_LOW;
        flow_tgt = 16'h01C2;
        step(4);
        chk({valve_close_o, flow_i}, 17'h10000);
        valve_sel_i = PAM_VALVE_HIGH;
        step(4);
        chk(valve_close_o, 0);
        a = alert_show_o;
        step(TICK_P);
        chk(alert_show_o, !a);
        flow_tgt = 16'h01F4;
        valve_sel_i = PAM_VALVE_OFF;
        step(3);
        chk({alarm_o, alert_show_o}, 0);
        flow_act_dly_i = 12'h004;
        flow_tgt = 16'h01C2;
        step(25);
        chk(alarm_o, 0);
        flow_tgt = 16'h01F4;
        step(3);
        flow_tgt = 16'h01C2;
        step(25);
        chk(alarm_o, 0);
        step(25);
        chk(alarm_o, 1);
        flow_act_dly_i = 12'h000;
        flow_latch_i = 1'b1;
        flow_tgt = 16'h01F4;
        step(3);
        chk(alarm_o, 1);
        flow_en_i = 1'b0;
        step(3);
        chk(alarm_o, 0);
        temp_en_i = 1'b0;
        temp_tgt = 16'hFFCD;
        step(3);
        chk(alarm_o, 0);
        temp_tgt = 16'h0064;
        pres_pon_dly_i = 12'h003;
        pres_tgt = 16'h00C7;
        sys_rst_i = 1'b1;
        step(2);
        sys_rst_i = 1'b0;
        step(20);
        chk(alarm_o, 0);
        step(40);
        chk(alarm_o, 6'h04);
        complete_run();
    end
endmodule
